// [rtl/gpx_top.sv]
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "gpx_defines.svh"
// Summary of operation
// - Ports 0-2 have 8-bit read/write output latches, reset to all ones.
// - Latch bit drives pin when output, else controls its weak pull-up.
// - Changing port direction never alters the output latch contents.
// - Port 3 latch holds bits 8:0, resets to ones; bits 15:9 read zero.
// - Edge flag sets on falling edge if select is one, rising if zero.
// - Flag stays set until software clear or reset; flag and enable request.
// - Software writing one to a flag requests an interrupt when enabled.
// - Edge flag register resets to zero and is freely read and written.
// - Enable bit n gates external interrupt n; register resets to zero.
// - Pin level register reads the current port 0 pin levels.
// - Input pin pull-up on when latch bit one, off when zero.
// - Only port 0 carries edge detection; ports 1-3 are plain ports.
// - Direction bit one makes the pin an output; directions reset zero.
// - Edge select register is read/write and resets to zero.
module gpx_top (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rstn,
    // Register port
    input  wire gpx_pkg::gpx_addr_t  addr,
    input  wire gpx_pkg::gpx_word_t  wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output gpx_pkg::gpx_word_t       rdata,
    // Interrupt request
    output logic                     irq,
    // Port 0 pins
    input  wire gpx_pkg::gpx_byte_t  p0_in,
    output gpx_pkg::gpx_byte_t       p0_out,
    output gpx_pkg::gpx_byte_t       p0_oe,
    output gpx_pkg::gpx_byte_t       p0_pullup,
    // Port 1 pins
    input  wire gpx_pkg::gpx_byte_t  p1_in,
    output gpx_pkg::gpx_byte_t       p1_out,
    output gpx_pkg::gpx_byte_t       p1_oe,
    output gpx_pkg::gpx_byte_t       p1_pullup,
    // Port 2 pins
    input  wire gpx_pkg::gpx_byte_t  p2_in,
    output gpx_pkg::gpx_byte_t       p2_out,
    output gpx_pkg::gpx_byte_t       p2_oe,
    output gpx_pkg::gpx_byte_t       p2_pullup,
    // Port 3 pins
    input  wire gpx_pkg::gpx_p3_t    p3_in,
    output gpx_pkg::gpx_p3_t         p3_out,
    output gpx_pkg::gpx_p3_t         p3_oe,
    output gpx_pkg::gpx_p3_t         p3_pullup
);
    import gpx_pkg::*;

    gpx_byte_t  p0_latch_r;
    gpx_byte_t  p1_latch_r;
    gpx_byte_t  p2_latch_r;
    gpx_p3_t    p3_latch_r;
    gpx_byte_t  dir0_r;
    gpx_byte_t  dir1_r;
    gpx_byte_t  dir2_r;
    gpx_p3_t    dir3_r;
    gpx_byte_t  flags_r;
    gpx_byte_t  flags_nxt;
    gpx_byte_t  enables_r;
    gpx_byte_t  edge_sel_r;
    gpx_word_t  rdata_r;
    gpx_word_t  rdata_nxt;
    logic       wr_p0;
    logic       wr_p1;
    logic       wr_p2;
    logic       wr_p3;
    logic       wr_flags;
    logic       wr_clr;
    logic       wr_en;
    logic       wr_sel;
    gpx_p3_t    p0_pull_w;
    gpx_p3_t    p1_pull_w;
    gpx_p3_t    p2_pull_w;

    gpx_edge_if edge_bus ();

    // Pull-up only for an input pin whose latch bit is one
    function automatic gpx_p3_t pull_on(input gpx_p3_t latch, input gpx_p3_t dir);
        pull_on = latch & ~dir;
    endfunction

    // Edge detector on port 0 only
    // port 0 interrupt logic
    gpx_edge_det u_edge (
        .mclk    (mclk),
        .rstn    (rstn),
        .pin_in  (p0_in),
        .edge_io (edge_bus.det)
    );
    assign edge_bus.polarity = edge_sel_r;

    // Write decode
    assign wr_p0    = wr && (addr == `GPX_OFS_P0_LATCH);
    assign wr_p1    = wr && (addr == `GPX_OFS_P1_LATCH);
    assign wr_p2    = wr && (addr == `GPX_OFS_P2_LATCH);
    assign wr_p3    = wr && (addr == `GPX_OFS_P3_LATCH);
    assign wr_flags = wr && (addr == `GPX_OFS_FLAGS);
    assign wr_clr   = wr && (addr == `GPX_OFS_FLAG_CLR);
    assign wr_en    = wr && (addr == `GPX_OFS_ENABLES);
    assign wr_sel   = wr && (addr == `GPX_OFS_EDGE_SEL);

    // only a latch write alters a latch
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            p0_latch_r <= `GPX_LATCH_RST;
            p1_latch_r <= `GPX_LATCH_RST;
            p2_latch_r <= `GPX_LATCH_RST;
        end else begin
            if (wr_p0) begin
                p0_latch_r <= wdata[7:0];
            end
            if (wr_p1) begin
                p1_latch_r <= wdata[7:0];
            end
            if (wr_p2) begin
                p2_latch_r <= wdata[7:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            // Only nine bits exist, so the sixteen-bit reset word is cut here
            p3_latch_r <= gpx_p3_t'(`GPX_P3_LATCH_RST);
        end else if (wr_p3) begin
            p3_latch_r <= wdata[`GPX_P3_MSB:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dir0_r <= `GPX_DIR_RST;
            dir1_r <= `GPX_DIR_RST;
            dir2_r <= `GPX_DIR_RST;
            // Same nine-bit cut as the port 3 latch
            dir3_r <= gpx_p3_t'(`GPX_DIR3_RST);
        end else if (wr) begin
            case (addr)
                `GPX_OFS_DIR0: begin
                    dir0_r <= wdata[7:0];
                end
                `GPX_OFS_DIR1: begin
                    dir1_r <= wdata[7:0];
                end
                `GPX_OFS_DIR2: begin
                    dir2_r <= wdata[7:0];
                end
                `GPX_OFS_DIR3: begin
                    dir3_r <= wdata[`GPX_P3_MSB:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            edge_sel_r <= `GPX_EDGE_SEL_RST;
        end else if (wr_sel) begin
            edge_sel_r <= wdata[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enables_r <= `GPX_ENABLES_RST;
        end else if (wr_en) begin
            enables_r <= wdata[7:0];
        end
    end

    // Flag next value: a direct write may set or clear, the clear register
    // drops the ones it names, and detected edges are ORed in last
    always_comb begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = wdata[7:0];
        end
        if (wr_clr) begin
            flags_nxt = flags_nxt & ~wdata[7:0];
        end
        flags_nxt = flags_nxt | edge_bus.edge_pulse;
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flags_r <= `GPX_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // level request while flagged and enabled; software must clear to drop it
    assign irq = |(flags_r & enables_r);

    // Read mux; unmapped and write-only offsets read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (rd) begin
            case (addr)
                `GPX_OFS_P0_LATCH:   rdata_nxt = {8'h00, p0_latch_r};
                `GPX_OFS_P1_LATCH:   rdata_nxt = {8'h00, p1_latch_r};
                `GPX_OFS_P2_LATCH:   rdata_nxt = {8'h00, p2_latch_r};
                `GPX_OFS_P3_LATCH:   rdata_nxt = {7'h00, p3_latch_r};
                `GPX_OFS_FLAGS:      rdata_nxt = {8'h00, flags_r};
                `GPX_OFS_ENABLES:    rdata_nxt = {8'h00, enables_r};
                `GPX_OFS_PIN_LEVELS: rdata_nxt = {8'h00, p0_in};
                `GPX_OFS_EDGE_SEL:   rdata_nxt = {8'h00, edge_sel_r};
                `GPX_OFS_DIR0:       rdata_nxt = {8'h00, dir0_r};
                `GPX_OFS_DIR1:       rdata_nxt = {8'h00, dir1_r};
                `GPX_OFS_DIR2:       rdata_nxt = {8'h00, dir2_r};
                `GPX_OFS_DIR3:       rdata_nxt = {7'h00, dir3_r};
                default:             rdata_nxt = 16'h0000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign rdata = rdata_r;

    // The helper works at the port 3 width; byte ports widen with a zero
    // and keep only their low byte
    assign p0_pull_w = pull_on({1'b0, p0_latch_r}, {1'b0, dir0_r});
    assign p1_pull_w = pull_on({1'b0, p1_latch_r}, {1'b0, dir1_r});
    assign p2_pull_w = pull_on({1'b0, p2_latch_r}, {1'b0, dir2_r});

    assign p0_out    = p0_latch_r;
    assign p0_oe     = dir0_r;
    assign p0_pullup = p0_pull_w[7:0];
    assign p1_out    = p1_latch_r;
    assign p1_oe     = dir1_r;
    assign p1_pullup = p1_pull_w[7:0];
    assign p2_out    = p2_latch_r;
    assign p2_oe     = dir2_r;
    assign p2_pullup = p2_pull_w[7:0];
    assign p3_out    = p3_latch_r;
    assign p3_oe     = dir3_r;
    assign p3_pullup = pull_on(p3_latch_r, dir3_r);

    // Checks on register and interrupt behaviour
    latch_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_p1 |=> (p1_latch_r == $past(wdata[7:0])))
        else $error("port 1 latch did not take written value");
    dir_keeps_latch_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wr && addr == `GPX_OFS_DIR0) |=> (p0_latch_r == $past(p0_latch_r)))
        else $error("direction write changed port 0 latch");
    p3_reserved_a: assert property (@(posedge mclk) disable iff (!rstn)
        (rd && addr == `GPX_OFS_P3_LATCH) |=> (rdata[15:9] == 7'h00)
            && (rdata[8:0] == $past(p3_latch_r)))
        else $error("port 3 latch read wrong or reserved bits set");
    edge_sets_a: assert property (@(posedge mclk) disable iff (!rstn)
        (edge_bus.edge_pulse != 8'h00) |=>
            ((flags_r & $past(edge_bus.edge_pulse)) == $past(edge_bus.edge_pulse)))
        else $error("detected edge did not set its flag");
    flag_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
        !(wr_flags || wr_clr) |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
        else $error("flag dropped without software clear");
    sw_set_irq_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_flags && ((wdata[7:0] & enables_r) != 8'h00) && !wr_en) |=> irq)
        else $error("software flag set did not raise interrupt");
    enable_off_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_en && wdata[7:0] == 8'h00) |=> !irq)
        else $error("interrupt stayed high with all enables cleared");
    pin_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        (rd && addr == `GPX_OFS_PIN_LEVELS) |=> (rdata[7:0] == $past(p0_in)))
        else $error("pin level read mismatch");
    pull_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_p1 |=> (p1_pullup == ($past(wdata[7:0]) & ~p1_oe)))
        else $error("port 1 pull-up does not follow latch");
    clr_flag_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_clr && edge_bus.edge_pulse == 8'h00) |=> ((flags_r & $past(wdata[7:0])) == 8'h00))
        else $error("flag clear did not clear");

    // Pins, directions and select follow their writes
    drive_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_p2 |=> (p2_out == $past(wdata[7:0])))
        else $error("port 2 pins miss latch write");
    p3_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_p3 |=> (p3_out == $past(wdata[8:0])))
        else $error("port 3 pins miss latch write");
    dir_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wr && addr == `GPX_OFS_DIR1) |=> (p1_oe == $past(wdata[7:0])))
        else $error("port 1 direction write lost");
    sel_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_sel |=> (edge_bus.polarity == $past(wdata[7:0])))
        else $error("edge select write lost");

    // Flags move only by edges or software
    flag_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_flags && edge_bus.edge_pulse == 8'h00) |=> (flags_r == $past(wdata[7:0])))
        else $error("flag register write lost");
    only_edges_a: assert property (@(posedge mclk) disable iff (!rstn)
        (!(wr_flags || wr_clr) && edge_bus.edge_pulse == 8'h00) |=> $stable(flags_r))
        else $error("flags moved without edge or write");
    edge_beats_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_clr && (wdata[7:0] & edge_bus.edge_pulse) != 8'h00)
            |=> ((flags_r & $past(edge_bus.edge_pulse)) != 8'h00))
        else $error("same-cycle clear beat an edge");
    irq_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        (irq && !wr_flags && !wr_clr && !wr_en) |=> irq)
        else $error("request dropped without software");
    level_rise_a: assert property (@(posedge mclk) disable iff (!rstn)
        (edge_bus.edge_pulse[0] && !edge_bus.polarity[0]) |-> edge_bus.level[0])
        else $error("pin 0 rise seen with level low");
    enable_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
        (wr_en && ((flags_r & wdata[7:0]) != 8'h00)) |=> irq)
        else $error("enabling a set flag gave no request");

    irq_rise_c: cover property (@(posedge mclk) disable iff (!rstn) $rose(irq));
    collide_c: cover property (@(posedge mclk) disable iff (!rstn)
        wr_clr && ((wdata[7:0] & edge_bus.edge_pulse) != 8'h00));
    p3_write_c: cover property (@(posedge mclk) disable iff (!rstn) wr_p3 ##1 rd);
    dir_keep_c: cover property (@(posedge mclk) disable iff (!rstn)
        (wr && addr == `GPX_OFS_DIR0) ##1 rd);
endmodule

// [rtl/gpx_defines.svh]
`ifndef GPX_DEFINES_SVH
`define GPX_DEFINES_SVH

// Register offsets on the plain register port
`define GPX_OFS_P0_LATCH   8'h00
`define GPX_OFS_P1_LATCH   8'h01
`define GPX_OFS_P2_LATCH   8'h02
`define GPX_OFS_P3_LATCH   8'h03
`define GPX_OFS_FLAGS      8'h04
`define GPX_OFS_ENABLES    8'h05
`define GPX_OFS_FLAG_CLR   8'h06
`define GPX_OFS_PIN_LEVELS 8'h08
`define GPX_OFS_EDGE_SEL   8'h0C
`define GPX_OFS_DIR0       8'h10
`define GPX_OFS_DIR1       8'h11
`define GPX_OFS_DIR2       8'h12
`define GPX_OFS_DIR3       8'h13

// Field positions
`define GPX_P3_MSB         8

// Reset values
`define GPX_LATCH_RST      8'hFF
`define GPX_P3_LATCH_RST   16'hFFFF
`define GPX_FLAGS_RST      8'h00
`define GPX_ENABLES_RST    8'h00
`define GPX_DIR_RST        8'h00
`define GPX_DIR3_RST       16'h0000
`define GPX_EDGE_SEL_RST   8'h00

// Clock edges after reset release before edge detection is trusted
`define GPX_SYNC_ARM       3

`endif

// [rtl/gpx_pkg.sv]
package gpx_pkg;
    typedef logic [7:0]  gpx_byte_t;
    typedef logic [15:0] gpx_word_t;
    typedef logic [7:0]  gpx_addr_t;
    typedef logic [8:0]  gpx_p3_t;
endpackage

// [rtl/gpx_edge_if.sv]
`timescale 1ns/1ps
// Edge events and polarity between the detector and the register core
interface gpx_edge_if;
    logic [7:0] polarity;
    logic [7:0] level;
    logic [7:0] edge_pulse;
    modport det  (input polarity, output level, output edge_pulse);
    modport core (output polarity, input level, input edge_pulse);
endinterface

// [rtl/gpx_edge_det.sv]
`timescale 1ns/1ps
`include "gpx_defines.svh"
module gpx_edge_det (
    // Clock and reset
    input wire logic          mclk,
    input wire logic          rstn,
    // Port 0 pin levels
    input wire gpx_pkg::gpx_byte_t pin_in,
    // Events toward the register core
    gpx_edge_if.det           edge_io
);
    import gpx_pkg::*;

    gpx_byte_t  sync1_r;
    gpx_byte_t  sync2_r;
    gpx_byte_t  prev_r;
    logic [2:0] arm_r;
    logic       armed;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
            prev_r  <= 8'h00;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Hold off detection until history holds real samples, else a high pin fakes a rise
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            arm_r <= 3'h0;
        end else begin
            arm_r <= {arm_r[1:0], 1'b1};
        end
    end
    assign armed = arm_r[`GPX_SYNC_ARM-1];

    assign edge_io.edge_pulse = armed ? ((edge_io.polarity & prev_r & ~sync2_r) |
                                         (~edge_io.polarity & ~prev_r & sync2_r)) : 8'h00;
    assign edge_io.level = sync2_r;

    rise_detect_a: assert property (@(posedge mclk) disable iff (!rstn)
        (armed && $rose(pin_in[0]) && !edge_io.polarity[0]) ##1 !edge_io.polarity[0]
        ##1 !edge_io.polarity[0] |-> edge_io.edge_pulse[0])
        else $error("rising edge on pin 0 not detected two cycles later");
    fall_detect_a: assert property (@(posedge mclk) disable iff (!rstn)
        (armed && $fell(pin_in[7]) && edge_io.polarity[7]) ##1 edge_io.polarity[7]
        ##1 edge_io.polarity[7] |-> edge_io.edge_pulse[7])
        else $error("falling edge on pin 7 not detected two cycles later");
    fall_cover: cover property (@(posedge mclk) disable iff (!rstn)
        edge_io.polarity[3] && edge_io.edge_pulse[3]);
endmodule

// [bench/gpx_pin_model.sv]
`timescale 1ns/1ps
// Board side of one port: external drivers, weak pull-ups and floating lines
module gpx_pin_model #(
    parameter int W = 8
) (
    // Clock
    input  wire logic         mclk,
    // Design side of the pads
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] pin_pullup,
    // Board drivers
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    // Resolved pad levels
    output logic [W-1:0]      pin_lvl
);
    logic [W-1:0] last_r = '0;
    logic [W-1:0] free_w;

    // A floating line without pull-up flips each cycle, so a stale level never passes
    assign free_w  = ~pin_oe & ~ext_en;
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                   | (free_w & pin_pullup) | (free_w & ~pin_pullup & ~last_r);

    // Last seen level of every pad; starts low so a floating line never sticks at unknown
    always @(posedge mclk) begin
        last_r <= pin_lvl;
    end
endmodule

// [bench/gpx_top_tb_top.sv]
`timescale 1ns/1ps
module gpx_top_tb_top;
    import gpx_pkg::*;
    logic      mclk;
    logic      rstn;
    gpx_addr_t addr;
    gpx_word_t wdata;
    logic      wr;
    logic      rd;
    gpx_word_t rdata;
    logic      irq;
    gpx_byte_t p0_in, p0_out, p0_oe, p0_pullup, p0_val, p0_en;
    gpx_byte_t p1_in, p1_out, p1_oe, p1_pullup, p1_val, p1_en;
    gpx_byte_t p2_in, p2_out, p2_oe, p2_pullup, p2_val, p2_en;
    gpx_p3_t   p3_in, p3_out, p3_oe, p3_pullup, p3_val, p3_en;
    int        errors;
    int        n_tests;
    int        cyc;

    gpx_top u_gpx_top (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq),
        .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pullup),
        .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p1_pullup(p1_pullup),
        .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p2_pullup(p2_pullup),
        .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe), .p3_pullup(p3_pullup));
    gpx_pin_model u_gpx_pin_model_0 (.mclk(mclk), .pin_out(p0_out),
        .pin_oe(p0_oe), .pin_pullup(p0_pullup), .ext_val(p0_val), .ext_en(p0_en),
        .pin_lvl(p0_in));
    gpx_pin_model u_gpx_pin_model_1 (.mclk(mclk), .pin_out(p1_out),
        .pin_oe(p1_oe), .pin_pullup(p1_pullup), .ext_val(p1_val), .ext_en(p1_en),
        .pin_lvl(p1_in));
    gpx_pin_model u_gpx_pin_model_2 (.mclk(mclk), .pin_out(p2_out),
        .pin_oe(p2_oe), .pin_pullup(p2_pullup), .ext_val(p2_val), .ext_en(p2_en),
        .pin_lvl(p2_in));
    gpx_pin_model #(.W(9)) u_gpx_pin_model_3 (.mclk(mclk), .pin_out(p3_out),
        .pin_oe(p3_oe), .pin_pullup(p3_pullup), .ext_val(p3_val), .ext_en(p3_en),
        .pin_lvl(p3_in));

    // Free-running clock, 4 ns period
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard well above the length of the sequence
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic chk_word(input string what, input gpx_word_t exp, input gpx_word_t got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One-cycle write strobe; the write lands at the closing edge
    task automatic wr_reg(input gpx_addr_t a, input gpx_word_t d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input gpx_addr_t a, input gpx_word_t exp, input string what);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk_word(what, exp, rdata);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic t_reset();
        rd_chk(8'h00, 16'h00FF, "latch0");             // latch reset
        rd_chk(8'h01, 16'h00FF, "latch1");             // latch reset
        rd_chk(8'h02, 16'h00FF, "latch2");             // latch reset
        rd_chk(8'h03, 16'h01FF, "latch3");             // upper bits zero
        rd_chk(8'h04, 16'h0000, "flags");              // flags reset
        rd_chk(8'h05, 16'h0000, "enables");            // enables reset
        rd_chk(8'h0C, 16'h0000, "edge select");        // select reset
        rd_chk(8'h10, 16'h0000, "dir0");               // direction reset
        rd_chk(8'h13, 16'h0000, "dir3");               // direction reset
        chk_word("p3_out", 16'h01FF, 16'(p3_out));     // pins follow latch
        chk_word("p0_pullup", 16'h00FF, 16'(p0_pullup)); // pull-ups on
        chk_word("p0_out", 16'h00FF, 16'(p0_out));     // latch on pins
        chk_word("p0_oe", 16'h0000, 16'(p0_oe));       // inputs at reset
        chk_bit("irq", 1'b0, irq);                     // no request
    endtask

    task automatic t_latch();
        wr_reg(8'h01, 16'hA5A5);
        rd_chk(8'h01, 16'h00A5, "latch1 rw");          // stored contents
        chk_word("p1_out", 16'h00A5, 16'(p1_out));     // latch to pins
        wr_reg(8'h03, 16'h0000);
        rd_chk(8'h03, 16'h0000, "latch3 clear");       // low bits writable
        wr_reg(8'h03, 16'hFFFF);
        rd_chk(8'h03, 16'h01FF, "latch3 set");         // reserved read zero
        rd_chk(8'h07, 16'h0000, "unmapped");           // no alias
        rd_chk(8'h06, 16'h0000, "clear reg");          // write-only clear
    endtask

    task automatic t_dir();
        wr_reg(8'h11, 16'h000F);
        wr_reg(8'h01, 16'h003C);
        chk_word("p1_oe", 16'h000F, 16'(p1_oe));       // one drives
        chk_word("p1_out", 16'h003C, 16'(p1_out));     // latch driven
        chk_word("p1_pullup", 16'h0030, 16'(p1_pullup)); // pull-up inputs
        wr_reg(8'h11, 16'h00F0);
        rd_chk(8'h01, 16'h003C, "latch1 kept");        // latch kept
        chk_word("p1_pullup2", 16'h000C, 16'(p1_pullup)); // pull-up inputs
        wr_reg(8'h10, 16'h00F0);
        rd_chk(8'h00, 16'h00FF, "latch0 kept");        // latch kept
        wr_reg(8'h10, 16'h0000);
        wr_reg(8'h12, 16'h0003);
        wr_reg(8'h02, 16'h0081);
        chk_word("p2_out", 16'h0081, 16'(p2_out));     // latch driven
        chk_word("p2_oe", 16'h0003, 16'(p2_oe));       // one drives
        chk_word("p2_pullup", 16'h0080, 16'(p2_pullup)); // pull-up inputs
        // Port 1 toggles must never reach the edge flags
        p1_en  <= 8'hFF;
        p1_val <= 8'h0F;
        wait_cyc(4);
        p1_val <= 8'hF0;
        wait_cyc(4);
        rd_chk(8'h04, 16'h0000, "p1 no flag");         // plain port
        wr_reg(8'h13, 16'h01FF);
        chk_word("p3_oe", 16'h01FF, 16'(p3_oe));       // nine bits
        chk_word("p3_pullup", 16'h0000, 16'(p3_pullup)); // driven pins
    endtask

    task automatic t_edge();
        gpx_byte_t b;
        wr_reg(8'h05, 16'h0055);
        for (int n = 0; n < 8; n++) begin
            b = 8'h01 << n;
            p0_val <= p0_val & ~b;
            wait_cyc(4);
            rd_chk(8'h04, 16'h0000, "fall ignored");   // rising selected
            p0_val <= p0_val | b;
            wait_cyc(4);
            rd_chk(8'h04, {8'h00, b}, "rise flag");    // pin n to flag n
            chk_bit("irq gate", (n % 2) == 0, irq);    // enable gates
            wait_cyc(10);
            rd_chk(8'h04, {8'h00, b}, "flag sticky");  // stays set
            rd_chk(8'h08, 16'h00FF, "levels high");    // pin levels
            wr_reg(8'h06, {8'h00, b});
            wr_reg(8'h0C, {8'h00, b});
            p0_val <= p0_val & ~b;
            wait_cyc(4);
            rd_chk(8'h04, {8'h00, b}, "fall flag");    // falling selected
            rd_chk(8'h08, {8'h00, ~b}, "levels low");  // pin levels
            wr_reg(8'h06, {8'h00, b});
            p0_val <= p0_val | b;
            wait_cyc(4);
            rd_chk(8'h04, 16'h0000, "rise ignored");   // falling selected
            wr_reg(8'h0C, 16'h0000);
        end
    endtask

    task automatic t_swset();
        wr_reg(8'h05, 16'h0080);
        wr_reg(8'h04, 16'h0080);
        wait_cyc(1);
        chk_bit("irq sw set", 1'b1, irq);              // write one requests
        rd_chk(8'h04, 16'h0080, "flags rw");           // free access
        // Software clears the serviced flag before returning
        wr_reg(8'h04, 16'h0000);                       // service clear
        wait_cyc(1);
        chk_bit("irq cleared", 1'b0, irq);             // clear drops request
        wr_reg(8'h04, 16'h0001);
        wait_cyc(1);
        chk_bit("irq masked", 1'b0, irq);              // disabled bit
        wr_reg(8'h06, 16'h0001);
        rd_chk(8'h04, 16'h0000, "w1c");                // software clear
    endtask

    // Rise on pin 0 timed so its edge lands with the clear or zero write
    task automatic t_collide();
        p0_val <= 8'hFE;
        wait_cyc(4);
        p0_val <= 8'hFF;
        wait_cyc(1);
        wr_reg(8'h06, 16'h0001);
        rd_chk(8'h04, 16'h0001, "edge beats clear");   // edge wins
        p0_val <= 8'hFE;
        wait_cyc(4);
        p0_val <= 8'hFF;
        wait_cyc(1);
        wr_reg(8'h04, 16'h0000);
        rd_chk(8'h04, 16'h0001, "edge beats write");   // edge wins
        wr_reg(8'h06, 16'h0001);
    endtask

    // Reset held two cycles, then time for the pin history to settle
    task automatic do_reset();
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        wait_cyc(4);
    endtask

    initial begin
        rstn    = 1'b0;
        addr    = 8'h00;
        wdata   = 16'h0000;
        wr      = 1'b0;
        rd      = 1'b0;
        p0_val  = 8'hFF;
        p0_en   = 8'hFF;
        p1_val  = 8'h00;
        p1_en   = 8'h00;
        p2_val  = 8'h00;
        p2_en   = 8'h00;
        p3_val  = 9'h000;
        p3_en   = 9'h000;
        errors  = 0;
        n_tests = 0;
        cyc     = 0;
        do_reset();
        t_reset();
        t_latch();
        t_dir();
        t_edge();
        t_swset();
        t_collide();
        wr_reg(8'h04, 16'h00AA);
        do_reset();
        t_reset();
        close_out();
    end
endmodule
